// ---- hdl/dma_regs_pkg.sv ----
// Purpose: Shared constants for the eight-channel DMA register block.
// Assumes: Byte addresses on a 32-bit Avalon-MM register bus.
// Notes:   Field positions refer to the channel configuration word.
package dma_regs_pkg;
  // Register map.
  localparam logic [31:0] STATUS_ADDR = 32'hA000_0000;
  localparam logic [31:0] CLEAR_ADDR  = 32'hA000_0004;
  localparam logic [31:0] CH_BASE     = 32'hA000_0008;
  localparam logic [31:0] CH_STRIDE   = 32'h0000_0014;
  localparam logic [31:0] CH_LAST     = 32'hA000_0094;
  localparam logic [31:0] GROUP_SPAN  = 32'h0000_0010;
  localparam logic [4:0]  OFF_CFG     = 5'h00;
  localparam logic [4:0]  OFF_CNT     = 5'h04;
  localparam logic [4:0]  OFF_PA      = 5'h08;
  localparam logic [4:0]  OFF_MA      = 5'h0C;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  // Configuration fields.
  localparam int B_EN      = 0;
  localparam int B_DONE_IE = 1;
  localparam int B_HALF_IE = 2;
  localparam int B_ERR_IE  = 3;
  localparam int B_DIR     = 4;
  localparam int B_WRAP    = 5;
  localparam int B_PSTEP   = 6;
  localparam int B_MSTEP   = 7;
  localparam int PW_LO     = 8;
  localparam int MW_LO     = 10;
  localparam int RANK_LO   = 12;
  localparam int B_COPY    = 14;
  localparam int CFG_W     = 15;
  // Per-channel flag nibble, same order in status and clear words.
  localparam int F_GLOBAL  = 0;
  localparam int F_DONE    = 1;
  localparam int F_HALF    = 2;
  localparam int F_ERR     = 3;
  localparam int FLAGS_PER_CH = 4;
  // Transfer widths.
  localparam logic [1:0] W8  = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;
  // Engine states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } eng_state_t;
endpackage

// ---- hdl/multi_channel_dma_regs.sv ----
// Purpose: Register file and single-beat transfer engine of an eight-channel DMA.
// Assumes: Peripheral requests and the master bus share sys_clk with this block.
// Notes:   Data moves through lane 0 upward; no byte-lane steering is done.
//
// Overview of operation
// R1: Channel 6 clear bits 24..27 clear flags.
// R2: Channel 7 clear bits 28..31 clear flags.
// R3: Zero clear bits change nothing; write-only.
// R4: Eight groups decoded, base 0xA0000008, stride 0x14.
// R5: Config, count, peripheral, memory at 0x00..0x0C.
// R6: Config bit 0 enables the channel.
// R7: Bit 1 gates done interrupt.
// R8: Bit 2 gates half interrupt.
// R9: Bit 3 gates error interrupt.
// R10: Bit 4 picks memory or peripheral source.
// R11: Bit 5 reloads block for circular operation.
// R12: Bit 6 advances peripheral address.
// R13: Bit 7 advances memory address.
// R14: Bits 9:8 set peripheral transfer width.
// R15: Bits 11:10 set memory transfer width.
// R16: Bits 13:12 rank the channel.
// R17: Bit 14 copies memory without request.
// R18: Count writable when disabled, decrements, reloads.
// R19: Wide transfers ignore low address bits.
// R20: Software writes reserved fields as zero.
// R21: Highest rank wins, ties lowest channel.
// R22: Events set flags; global follows any.
`timescale 1ns/1ps
module multi_channel_dma_regs #(
  parameter int NUM_CH = 8,
  parameter int CNT_W  = 16
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Avalon-MM register slave.
  input  wire logic [31:0]         avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // Avalon-MM transfer master.
  output logic      [31:0]         mst_address,
  output logic                     mst_read,
  output logic                     mst_write,
  output logic      [31:0]         mst_writedata,
  output logic      [1:0]          mst_width,
  input  wire logic [31:0]         mst_readdata,
  input  wire logic                mst_waitrequest,
  input  wire logic                mst_error,
  // Peripheral handshake.
  input  wire logic [NUM_CH-1:0]   periph_req,
  output logic      [NUM_CH-1:0]   periph_ack,
  // Per-channel interrupt requests.
  output logic      [NUM_CH-1:0]   irq_req
);
  localparam int CFG_W_L = dma_regs_pkg::CFG_W;
  localparam int FLAGS_W = NUM_CH * dma_regs_pkg::FLAGS_PER_CH;
  localparam int CH_IW   = $clog2(NUM_CH);
  // Channel state.
  logic [CFG_W_L-1:0]  cfg_r    [NUM_CH];
  logic [CNT_W-1:0]    cnt_r    [NUM_CH];
  logic [CNT_W-1:0]    reload_r [NUM_CH];
  logic [31:0]         pa_r     [NUM_CH];
  logic [31:0]         ma_r     [NUM_CH];
  logic [31:0]         cur_pa_r [NUM_CH];
  logic [31:0]         cur_ma_r [NUM_CH];
  logic [FLAGS_W-1:0]  flags_r;
  // Bus slave state.
  logic                ack_r;
  logic [31:0]         rdata_r;
  logic                hit;
  logic [CH_IW-1:0]    hit_ch;
  logic [4:0]          hit_off;
  logic                wr_go;
  // Engine state.
  dma_regs_pkg::eng_state_t st_r;
  logic [CH_IW-1:0]    sel_r;
  logic [31:0]         buf_r;
  logic                grant;
  logic [CH_IW-1:0]    grant_ch;
  logic                beat_done;
  logic                beat_err;
  logic [CNT_W-1:0]    cnt_next;
  // Width field to address step in bytes.
  function automatic logic [31:0] step_of(input logic [1:0] w);
    case (w)
      dma_regs_pkg::W16: step_of = 32'h0000_0002;
      dma_regs_pkg::W32: step_of = 32'h0000_0004;
      default:           step_of = 32'h0000_0001;
    endcase
  endfunction

  // Drops the address bits that the width makes meaningless.
  function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] w);
    case (w)
      dma_regs_pkg::W16: align = {a[31:1], 1'b0}; // R19
      dma_regs_pkg::W32: align = {a[31:2], 2'b00}; // R19
      default:           align = a;
    endcase
  endfunction

  // Channel group decode; the stride is not a power of two so each base is compared.
  always_comb
  begin
    logic [31:0] diff;
    diff    = 32'h0000_0000;
    hit     = 1'b0;
    hit_ch  = '0;
    hit_off = 5'h00;
    for (int i = 0; i < NUM_CH; i++)
    begin
      diff = avs_address - (dma_regs_pkg::CH_BASE + 32'(i) * dma_regs_pkg::CH_STRIDE); // R4
      if (diff < dma_regs_pkg::GROUP_SPAN && avs_address[1:0] == 2'b00)
      begin
        hit     = 1'b1;
        hit_ch  = CH_IW'(i);
        hit_off = diff[4:0];
      end
    end
  end
  // One wait state on every access: the answer is built in the first cycle.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r;
  assign avs_readdata    = rdata_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // Read data mux; clear word is write-only and unmapped space reads zero.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= dma_regs_pkg::RESET_WORD;
    else if (avs_read && !ack_r)
    begin
      rdata_r <= dma_regs_pkg::RESET_WORD;
      if (avs_address == dma_regs_pkg::STATUS_ADDR)
        rdata_r <= 32'(flags_r);
      else if (hit)
      begin
        case (hit_off) // R5
          dma_regs_pkg::OFF_CFG: rdata_r <= 32'(cfg_r[hit_ch]);
          dma_regs_pkg::OFF_CNT: rdata_r <= 32'(cnt_r[hit_ch]);
          dma_regs_pkg::OFF_PA:  rdata_r <= pa_r[hit_ch];
          dma_regs_pkg::OFF_MA:  rdata_r <= ma_r[hit_ch];
          default:               rdata_r <= dma_regs_pkg::RESET_WORD;
        endcase
      end
    end
  end

  // Arbiter: strictly greater rank replaces, so ties keep the lower channel.
  always_comb
  begin
    logic [1:0] best;
    logic       ready;
    best     = 2'b00;
    ready    = 1'b0;
    grant    = 1'b0;
    grant_ch = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      ready = cfg_r[i][dma_regs_pkg::B_EN] && cnt_r[i] != '0 // R18
              && (cfg_r[i][dma_regs_pkg::B_COPY] || periph_req[i]); // R17
      if (ready && (!grant || cfg_r[i][dma_regs_pkg::RANK_LO +: 2] > best)) // R16 R21
      begin
        grant    = 1'b1;
        grant_ch = CH_IW'(i);
        best     = cfg_r[i][dma_regs_pkg::RANK_LO +: 2];
      end
    end
  end
  // A beat counts only at its accepting edge; an idle slave may show no wait or a stale error.
  assign beat_done = (st_r == dma_regs_pkg::ST_WRITE) && mst_write && !mst_waitrequest;
  assign beat_err  = (mst_read || mst_write) && !mst_waitrequest && mst_error;
  assign cnt_next  = cnt_r[sel_r] - CNT_W'(1);
  // Engine: one read beat then one write beat per served request.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    logic [31:0] src;
    logic [31:0] dst;
    logic [1:0]  sw;
    logic [1:0]  dw;
    if (rst)
    begin
      st_r          <= dma_regs_pkg::ST_IDLE;
      sel_r         <= '0;
      buf_r         <= dma_regs_pkg::RESET_WORD;
      mst_address   <= dma_regs_pkg::RESET_WORD;
      mst_read      <= 1'b0;
      mst_write     <= 1'b0;
      mst_writedata <= dma_regs_pkg::RESET_WORD;
      mst_width     <= dma_regs_pkg::W8;
      periph_ack    <= '0;
    end
    else
    begin
      periph_ack <= '0;
      src = cur_pa_r[sel_r];
      dst = cur_ma_r[sel_r];
      sw  = cfg_r[sel_r][dma_regs_pkg::PW_LO +: 2]; // R14
      dw  = cfg_r[sel_r][dma_regs_pkg::MW_LO +: 2]; // R15
      if (cfg_r[sel_r][dma_regs_pkg::B_DIR]) // R10
      begin
        src = cur_ma_r[sel_r];
        dst = cur_pa_r[sel_r];
        sw  = cfg_r[sel_r][dma_regs_pkg::MW_LO +: 2];
        dw  = cfg_r[sel_r][dma_regs_pkg::PW_LO +: 2];
      end
      case (st_r)
        dma_regs_pkg::ST_IDLE:
        begin
          if (grant)
          begin
            sel_r <= grant_ch;
            st_r  <= dma_regs_pkg::ST_READ;
          end
        end
        dma_regs_pkg::ST_READ:
        begin
          mst_read    <= 1'b1;
          mst_address <= align(src, sw); // R19
          mst_width   <= sw;
          if (mst_read && !mst_waitrequest)
          begin
            mst_read <= 1'b0;
            buf_r    <= mst_readdata;
            st_r     <= mst_error ? dma_regs_pkg::ST_IDLE : dma_regs_pkg::ST_WRITE;
          end
        end
        dma_regs_pkg::ST_WRITE:
        begin
          mst_write     <= 1'b1;
          mst_address   <= align(dst, dw); // R19
          mst_width     <= dw;
          mst_writedata <= buf_r;
          if (mst_write && !mst_waitrequest)
          begin
            mst_write         <= 1'b0;
            periph_ack[sel_r] <= ~cfg_r[sel_r][dma_regs_pkg::B_COPY];
            st_r              <= dma_regs_pkg::ST_IDLE;
          end
        end
        default: st_r <= dma_regs_pkg::ST_IDLE;
      endcase
    end
  end

  // Configuration: an error on the bus disables the faulting channel.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        cfg_r[i] <= '0; // R6
    end
    else
    begin
      if (wr_go && hit && hit_off == dma_regs_pkg::OFF_CFG)
        cfg_r[hit_ch] <= avs_writedata[CFG_W_L-1:0]; // R6 R20
      if (beat_err && mst_error)
        cfg_r[sel_r][dma_regs_pkg::B_EN] <= 1'b0;
    end
  end

  // Count and reload value; writes are refused while the channel runs.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        cnt_r[i]    <= '0;
        reload_r[i] <= '0;
      end
    end
    else
    begin
      if (wr_go && hit && hit_off == dma_regs_pkg::OFF_CNT
          && !cfg_r[hit_ch][dma_regs_pkg::B_EN]) // R18
      begin
        cnt_r[hit_ch]    <= avs_writedata[CNT_W-1:0];
        reload_r[hit_ch] <= avs_writedata[CNT_W-1:0];
      end
      if (beat_done && !mst_error)
      begin
        if (cnt_next == '0 && cfg_r[sel_r][dma_regs_pkg::B_WRAP]) // R11
          cnt_r[sel_r] <= reload_r[sel_r];
        else
          cnt_r[sel_r] <= cnt_next; // R18
      end
    end
  end

  // Programmed and running addresses; a disabled channel tracks its programmed base.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    logic wrap_end;
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        pa_r[i]     <= dma_regs_pkg::RESET_WORD;
        ma_r[i]     <= dma_regs_pkg::RESET_WORD;
        cur_pa_r[i] <= dma_regs_pkg::RESET_WORD;
        cur_ma_r[i] <= dma_regs_pkg::RESET_WORD;
      end
    end
    else
    begin
      wrap_end = cnt_next == '0 && cfg_r[sel_r][dma_regs_pkg::B_WRAP];
      if (wr_go && hit && hit_off == dma_regs_pkg::OFF_PA)
        pa_r[hit_ch] <= avs_writedata;
      if (wr_go && hit && hit_off == dma_regs_pkg::OFF_MA)
        ma_r[hit_ch] <= avs_writedata;
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (!cfg_r[i][dma_regs_pkg::B_EN])
        begin
          cur_pa_r[i] <= pa_r[i];
          cur_ma_r[i] <= ma_r[i];
        end
      end
      if (beat_done && !mst_error)
      begin
        if (wrap_end) // R11
        begin
          cur_pa_r[sel_r] <= pa_r[sel_r];
          cur_ma_r[sel_r] <= ma_r[sel_r];
        end
        else
        begin
          if (cfg_r[sel_r][dma_regs_pkg::B_PSTEP]) // R12
            cur_pa_r[sel_r] <= cur_pa_r[sel_r]
                               + step_of(cfg_r[sel_r][dma_regs_pkg::PW_LO +: 2]);
          if (cfg_r[sel_r][dma_regs_pkg::B_MSTEP]) // R13
            cur_ma_r[sel_r] <= cur_ma_r[sel_r]
                               + step_of(cfg_r[sel_r][dma_regs_pkg::MW_LO +: 2]);
        end
      end
    end
  end

  // Flags: a hardware event in the same cycle as a clear survives it.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    logic [FLAGS_W-1:0] clr;
    logic [FLAGS_W-1:0] set;
    if (rst)
      flags_r <= '0;
    else
    begin
      clr = '0;
      set = '0;
      if (wr_go && avs_address == dma_regs_pkg::CLEAR_ADDR)
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          // Zero bits leave the flags alone; the global bit takes all four.
          if (avs_writedata[i*4 + dma_regs_pkg::F_GLOBAL]) // R1 R2 R3
            clr[i*4 +: 4] = 4'hF;
          clr[i*4 + dma_regs_pkg::F_DONE] |= avs_writedata[i*4 + dma_regs_pkg::F_DONE];
          clr[i*4 + dma_regs_pkg::F_HALF] |= avs_writedata[i*4 + dma_regs_pkg::F_HALF];
          clr[i*4 + dma_regs_pkg::F_ERR]  |= avs_writedata[i*4 + dma_regs_pkg::F_ERR];
        end
      end
      if (beat_err && mst_error)
        set[32'(sel_r) * 4 + dma_regs_pkg::F_ERR] = 1'b1; // R22
      if (beat_done && !mst_error)
      begin
        if (cnt_next == '0)
          set[32'(sel_r) * 4 + dma_regs_pkg::F_DONE] = 1'b1; // R22
        if (cnt_next == (reload_r[sel_r] >> 1))
          set[32'(sel_r) * 4 + dma_regs_pkg::F_HALF] = 1'b1; // R22
      end
      for (int i = 0; i < NUM_CH; i++)
        if (|set[i*4 +: 4])
          set[i*4 + dma_regs_pkg::F_GLOBAL] = 1'b1; // R22
      flags_r <= (flags_r & ~clr) | set;
    end
  end

  // Interrupt requests gated by the per-channel enables.
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      irq_req[i] = (flags_r[i*4 + dma_regs_pkg::F_DONE] & cfg_r[i][dma_regs_pkg::B_DONE_IE]) // R7
                 | (flags_r[i*4 + dma_regs_pkg::F_HALF] & cfg_r[i][dma_regs_pkg::B_HALF_IE]) // R8
                 | (flags_r[i*4 + dma_regs_pkg::F_ERR] & cfg_r[i][dma_regs_pkg::B_ERR_IE]); // R9
  end

endmodule

// ---- sim/dma_bus_model.sv ----
// Purpose: Bus model of the memory and peripherals behind the DMA master port.
// Assumes: One beat at a time; read data is the inverted beat address.
// Notes:   BAD_ADDR answers with an error so that the fault path can be reached.
`timescale 1ns/1ps
module dma_bus_model #(
  parameter int          WAITS    = 2,
  parameter logic [31:0] BAD_ADDR = 32'h0000_0BAD
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Master requests.
  input  wire logic [31:0] mst_address,
  input  wire logic        mst_read,
  input  wire logic        mst_write,
  input  wire logic [31:0] mst_writedata,
  // Slave answers.
  output logic      [31:0] mst_readdata,
  output logic             mst_waitrequest,
  output logic             mst_error,
  // Last accepted write.
  output logic      [31:0] wr_addr,
  output logic      [31:0] wr_data
);
  logic [3:0] wait_r;
  logic       tog_r;
  // Idle data toggles, so a design that samples it outside a beat sees garbage.
  assign mst_waitrequest = (mst_read | mst_write) & (wait_r != 4'(WAITS));
  assign mst_readdata    = mst_read ? ~mst_address : {16{tog_r, ~tog_r}};
  assign mst_error       = (mst_address == BAD_ADDR);
  // Stall each beat for WAITS cycles before accepting it.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_r <= 4'h0;
      tog_r  <= 1'b0;
    end
    else
    begin
      tog_r  <= ~tog_r;
      wait_r <= mst_waitrequest ? wait_r + 4'h1 : 4'h0;
    end
  end
  // Keep the last accepted write for the bench to inspect.
  always_ff @(posedge sys_clk)
  begin
    if (mst_write & ~mst_waitrequest)
    begin
      wr_addr <= mst_address;
      wr_data <= mst_writedata;
    end
  end
endmodule

// ---- sim/multi_channel_dma_regs_asserts.sv ----
// Purpose: Port checks for the DMA register block.
// Assumes: One clock domain, rst asynchronous and active high.
// Notes:   Flags are judged through irq_req only; status reads on avs_readdata are not watched here.
`timescale 1ns/1ps
module multi_channel_dma_regs_asserts #(
  parameter int NUM_CH = 8
) (
  // Clock and reset.
  input wire logic              sys_clk,
  input wire logic              rst,
  // Register slave.
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  // Transfer master.
  input wire logic [31:0]       mst_address,
  input wire logic              mst_read,
  input wire logic              mst_write,
  input wire logic [1:0]        mst_width,
  input wire logic              mst_waitrequest,
  input wire logic              mst_error,
  // Handshake and interrupts.
  input wire logic [NUM_CH-1:0] periph_ack,
  input wire logic [NUM_CH-1:0] irq_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rd_ok;
  logic wr_ok;
  logic reg_wr;
  logic irq_why;
  // Accepted beats; a flag may only move on one of these.
  assign rd_ok   = mst_read & ~mst_waitrequest;
  assign wr_ok   = mst_write & ~mst_waitrequest;
  assign reg_wr  = avs_write & ~avs_waitrequest;
  assign irq_why = wr_ok | reg_wr | (rd_ok & mst_error);
  sequence one_wait_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence good_read_s;
    rd_ok & ~mst_error;
  endsequence
  wait_one_a: assert property ($rose(avs_read | avs_write) |-> one_wait_s)
    else $error("register access not answered after one wait state");
  hold_req_a: assert property (mst_read & mst_waitrequest |=> mst_read & $stable(mst_address))
    else $error("master read dropped or moved before acceptance");
  rd_wr_a: assert property (good_read_s |-> ##[1:3] mst_write)
    else $error("read beat not followed by its write");
  err_stop_a: assert property (rd_ok & mst_error |=> !mst_write [*3])
    else $error("write issued after a failed read");
  ack_pulse_a: assert property (|periph_ack |-> $past(wr_ok) ##1 !(|periph_ack))
    else $error("peripheral ack not a single pulse after a write");
  align_word_a: assert property ((mst_read | mst_write) && mst_width == 2'h2
    |-> mst_address[1:0] == 2'h0)
    else $error("word beat not word aligned");
  align_half_a: assert property ((mst_read | mst_write) && mst_width == 2'h1
    |-> !mst_address[0])
    else $error("halfword beat not halfword aligned");
  irq_rise_a: assert property ($rose(|irq_req) |-> $past(irq_why) || $past(irq_why, 2))
    else $error("interrupt rose without a beat or register write");
  irq_fall_a: assert property ($fell(|irq_req) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell without a register write");
endmodule
bind multi_channel_dma_regs multi_channel_dma_regs_asserts #(.NUM_CH(NUM_CH)) asserts_inst (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .mst_address(mst_address), .mst_read(mst_read),
  .mst_write(mst_write), .mst_width(mst_width), .mst_waitrequest(mst_waitrequest),
  .mst_error(mst_error), .periph_ack(periph_ack), .irq_req(irq_req));

// ---- sim/tb_multi_channel_dma_regs.sv ----
// Purpose: Self-checking bench for the eight-channel DMA register block.
// Assumes: Bus model stalls two cycles per beat; address 0xBAD faults.
// Notes:   Scenarios run one after another so every expectation is exact.
`timescale 1ns/1ps
module tb_multi_channel_dma_regs;
  localparam logic [31:0] STAT = dma_regs_pkg::STATUS_ADDR;
  localparam logic [31:0] CLR  = dma_regs_pkg::CLEAR_ADDR;
  logic        sys_clk = 1'b0;
  logic        rst;
  logic [31:0] avs_address, avs_writedata, avs_readdata, v, w, m;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] mst_address, mst_writedata, mst_readdata, wr_addr, wr_data;
  logic        mst_read, mst_write, mst_waitrequest, mst_error;
  logic [1:0]  mst_width;
  logic [7:0]  periph_req, periph_ack, irq_req, ack;
  logic [7:0]  order [3] = '{8'h02, 8'h04, 8'h01};
  int          n_fail = 0;
  int          tests_run = 0;
  multi_channel_dma_regs multi_channel_dma_regs_inst (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mst_address(mst_address), .mst_read(mst_read), .mst_write(mst_write),
    .mst_writedata(mst_writedata), .mst_width(mst_width), .mst_readdata(mst_readdata),
    .mst_waitrequest(mst_waitrequest), .mst_error(mst_error), .periph_req(periph_req),
    .periph_ack(periph_ack), .irq_req(irq_req));
  dma_bus_model dma_bus_model_inst (
    .sys_clk(sys_clk), .rst(rst), .mst_address(mst_address), .mst_read(mst_read),
    .mst_write(mst_write), .mst_writedata(mst_writedata), .mst_readdata(mst_readdata),
    .mst_waitrequest(mst_waitrequest), .mst_error(mst_error), .wr_addr(wr_addr),
    .wr_data(wr_data));
  // A 40 ns period gives the 25 MHz system clock.
  always #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] ra(input int i, o);
    return dma_regs_pkg::CH_BASE + dma_regs_pkg::CH_STRIDE * 32'(i) + 32'(4 * o);
  endfunction
  // Compare one result; a mismatch is reported at once.
  task automatic chk(input string nm, input logic [31:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The request stands until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0, v);
    chk(nm, v, e);
  endtask
  // Count goes before config, because it is locked once the channel runs.
  task automatic cfg_ch(input int i, input logic [31:0] pa, ma, cnt, cfg);
    bus(1'b1, ra(i, 2), pa, v);
    bus(1'b1, ra(i, 3), ma, v);
    bus(1'b1, ra(i, 1), cnt, v);
    bus(1'b1, ra(i, 0), cfg, v);
  endtask
  task automatic poll(input logic [31:0] a, msk);
    repeat (50)
    begin
      bus(1'b0, a, 32'h0, v);
      if ((v & msk) === msk)
        break;
    end
  endtask
  task automatic wait_ack;
    ack = 8'h00;
    repeat (200)
    begin
      @(posedge sys_clk);
      ack = periph_ack;
      if (|ack)
        break;
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: the scenarios need under 1000 cycles, so 20000 means a hang.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end
  // Main sequence: reset, map, locking, transfers, faults and arbitration.
  initial
  begin
    rst           <= 1'b1;
    avs_address   <= 32'h0;
    avs_writedata <= 32'h0;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    periph_req    <= 8'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      for (int o = 0; o < 4; o++)
      begin
        m = (o == 0) ? 32'h7FFE : (o == 1) ? 32'hFFFF : 32'hFFFF_FFFF;
        w = (32'hC3A5_FFFE - 32'(2 * (4 * i + o))) & m;
        rdchk("reset value", ra(i, o), 32'h0);
        bus(1'b1, ra(i, o), w, v);
        rdchk("readback", ra(i, o), w);
      end
      bus(1'b1, ra(i, 0), 32'h0, v);
    end
    rdchk("group hole", ra(0, 4), 32'h0);
    rdchk("past last group", ra(8, 0), 32'h0);
    cfg_ch(0, 32'h0, 32'h0, 32'h3, 32'h1);
    bus(1'b1, ra(0, 1), 32'h9, v);
    rdchk("locked count", ra(0, 1), 32'h3);
    rdchk("enable", ra(0, 0), 32'h1);
    bus(1'b1, ra(0, 0), 32'h0, v);
    // Peripheral to memory, word wide, memory side stepping.
    cfg_ch(6, 32'h100, 32'h2000, 32'h4, 32'hA8F);
    periph_req <= 8'h40;
    repeat (4)
    begin
      wait_ack();
      chk("ack ch6", 32'(ack), 32'h40);
    end
    periph_req <= 8'h00;
    chk("last dest", wr_addr, 32'h200C);
    chk("moved data", wr_data, 32'hFFFF_FEFF);
    rdchk("count spent", ra(6, 1), 32'h0);
    rdchk("ch6 flags", STAT, 32'h0700_0000);
    chk("irq ch6", 32'(irq_req), 32'h40);
    bus(1'b1, CLR, 32'h0200_0000, v);
    rdchk("done cleared", STAT, 32'h0500_0000);
    chk("half irq", 32'(irq_req), 32'h40);
    bus(1'b1, CLR, 32'h0, v);
    rdchk("zero clear", STAT, 32'h0500_0000);
    bus(1'b1, CLR, 32'h0400_0000, v);
    rdchk("half cleared", STAT, 32'h0100_0000);
    bus(1'b1, CLR, 32'h0100_0000, v);
    rdchk("global cleared", STAT, 32'h0);
    rdchk("clear word", CLR, 32'h0);
    chk("irq quiet", 32'(irq_req), 32'h0);
    // Memory copy without any request, interrupts masked, memory as source.
    cfg_ch(5, 32'h500, 32'h5055, 32'h1, 32'h4011);
    poll(STAT, 32'h0020_0000);
    rdchk("copy flags", STAT, 32'h0070_0000);
    chk("masked irq", 32'(irq_req), 32'h0);
    chk("copy dest", wr_addr, 32'h500);
    chk("copy data", 32'(wr_data[7:0]), 32'hAA);
    bus(1'b1, CLR, 32'h0010_0000, v);
    // Faulting read disables the channel and keeps its count.
    cfg_ch(7, 32'h0000_0BAD, 32'h3000, 32'h2, 32'h9);
    periph_req <= 8'h80;
    poll(STAT, 32'h8000_0000);
    periph_req <= 8'h00;
    rdchk("error flags", STAT, 32'h9000_0000);
    rdchk("auto disable", ra(7, 0), 32'h8);
    rdchk("count kept", ra(7, 1), 32'h2);
    chk("error irq", 32'(irq_req), 32'h80);
    bus(1'b1, CLR, 32'h2000_0000, v);
    rdchk("done only", STAT, 32'h9000_0000);
    bus(1'b1, CLR, 32'h8000_0000, v);
    rdchk("error cleared", STAT, 32'h1000_0000);
    bus(1'b1, CLR, 32'h1000_0000, v);
    rdchk("all cleared", STAT, 32'h0);
    // Circular, both sides stepping bytewise; the third ack is one grant too late to stop a fourth.
    cfg_ch(3, 32'h600, 32'h7000, 32'h2, 32'hE1);
    periph_req <= 8'h08;
    for (int k = 0; k < 4; k++)
    begin
      wait_ack();
      if (k == 2)
        periph_req <= 8'h00;
      chk("wrap dest", wr_addr, 32'h7000 + 32'(k % 2));
      chk("wrap data", wr_data, ~(32'h600 + 32'(k % 2)));
    end
    rdchk("wrap reload", ra(3, 1), 32'h2);
    rdchk("ch3 flags", STAT, 32'h0000_7000);
    bus(1'b1, CLR, 32'h0000_1000, v);
    // Rank decides first, then the lower channel number.
    cfg_ch(0, 32'h301, 32'h4000, 32'h1, 32'h101);
    cfg_ch(1, 32'h301, 32'h4100, 32'h1, 32'h3101);
    cfg_ch(2, 32'h301, 32'h4200, 32'h1, 32'h3101);
    periph_req <= 8'h07;
    for (int k = 0; k < 3; k++)
    begin
      wait_ack();
      chk("grant order", 32'(ack), 32'(order[k]));
    end
    periph_req <= 8'h00;
    close_out();
  end
endmodule
